/* rtl/xfer_pkg.sv */
// Shared constants and types for the four channel transfer controller.
// Assumes one clock domain, the peripheral request lines and a single core bus port.
package xfer_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;

  // ==========================================================================
  // Transfer kinds and request sources
  // ==========================================================================
  typedef enum logic [1:0] {
    DIR_MEM_TO_PER,
    DIR_PER_TO_MEM,
    DIR_MEM_TO_MEM
  } xfer_dir_e;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_PRIMARY,
    SRC_SECONDARY,
    SRC_SOFTWARE
  } req_src_e;

  // Peripheral request lines, one bit per source.
  typedef struct packed {
    logic usb;
    logic uart_rx;
    logic uart_tx;
    logic audio_rx;
    logic audio_tx;
    logic conv_rx;
    logic conv_tx;
  } per_req_s;

  // Per channel setup as programmed by the processor side.
  typedef struct packed {
    logic enable;
    xfer_dir_e dir;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [CNT_W-1:0] count;
  } ch_cfg_s;

  // One bus cycle request toward the core bus.
  typedef struct packed {
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000002;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

endpackage

/* rtl/xfer_channel.sv */
// One independent transfer channel with its request selection and address counters.
// Assumes the parent grants at most one channel a bus cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module xfer_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire xfer_pkg::ch_cfg_s cfg,
  input wire logic cfg_load,
  input wire logic prim_req,
  input wire logic sec_req,
  input wire logic sw_req,
  input wire logic grant,
  input wire logic bus_done,
  input wire logic [xfer_pkg::DATA_W-1:0] bus_rdata,
  output xfer_pkg::bus_req_s bus_out,
  output xfer_pkg::req_src_e src,
  output logic prim_ack,
  output logic sec_ack,
  output logic busy,
  output logic finished
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } ch_state_e;

  ch_state_e state_r, state_nxt;
  xfer_pkg::ch_cfg_s cfg_r;
  xfer_pkg::req_src_e src_r;
  logic [xfer_pkg::DATA_W-1:0] data_r;
  logic finished_r;

  // ==========================================================================
  // Request selection
  // ==========================================================================
  // Primary before secondary.
  wire xfer_pkg::req_src_e pick = prim_req ? xfer_pkg::SRC_PRIMARY :
                                  sec_req ? xfer_pkg::SRC_SECONDARY :
                                  sw_req ? xfer_pkg::SRC_SOFTWARE : xfer_pkg::SRC_NONE;
  wire logic go = cfg_r.enable && (cfg_r.count != xfer_pkg::CNT_ZERO)
                  && (pick != xfer_pkg::SRC_NONE);
  wire logic last = (cfg_r.count == xfer_pkg::CNT_ONE);
  wire logic done_here = grant && bus_done;

  // Read phase reads the source, write phase writes the destination.
  assign bus_out.req = (state_r != ST_IDLE);
  assign bus_out.wr = (state_r == ST_WRITE);
  assign bus_out.addr = (state_r == ST_WRITE) ? cfg_r.dst_addr : cfg_r.src_addr;
  assign bus_out.wdata = data_r;
  assign src = src_r;
  assign busy = (state_r != ST_IDLE);
  assign finished = finished_r;
  // The acknowledge frees a held peripheral request at the end of its write.
  assign prim_ack = done_here && (state_r == ST_WRITE) && (src_r == xfer_pkg::SRC_PRIMARY);
  assign sec_ack = done_here && (state_r == ST_WRITE) && (src_r == xfer_pkg::SRC_SECONDARY);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (done_here) begin
          state_nxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (done_here) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State and counters
  // ==========================================================================
  // Each channel holds its own state.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cfg_r <= '0;
      src_r <= xfer_pkg::SRC_NONE;
      data_r <= '0;
      finished_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      finished_r <= 1'b0;
      if (cfg_load && state_r == ST_IDLE) begin
        cfg_r <= cfg;
      end
      if (state_r == ST_IDLE && go) begin
        src_r <= pick;
      end
      if (done_here && state_r == ST_READ) begin
        data_r <= bus_rdata;
      end
      if (done_here && state_r == ST_WRITE) begin
        cfg_r.count <= cfg_r.count - xfer_pkg::CNT_ONE;
        finished_r <= last;
        if (cfg_r.dir != xfer_pkg::DIR_PER_TO_MEM) begin
          cfg_r.src_addr <= cfg_r.src_addr + xfer_pkg::ADDR_STEP;
        end
        if (cfg_r.dir != xfer_pkg::DIR_MEM_TO_PER) begin
          cfg_r.dst_addr <= cfg_r.dst_addr + xfer_pkg::ADDR_STEP;
        end
      end
    end
  end

  a_ack_in_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    prim_ack |-> (state_r == ST_WRITE && src_r == xfer_pkg::SRC_PRIMARY))
    else $error("primary acknowledge outside its write cycle");

  a_prim_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && state_r == ST_IDLE && go && prim_req) |=> (src_r == xfer_pkg::SRC_PRIMARY))
    else $error("secondary served before a pending primary");

  a_read_then_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && state_r == ST_READ && done_here) |=> (state_r == ST_WRITE))
    else $error("write phase did not follow the read");

  a_count_drops: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && state_r == ST_WRITE && done_here && !cfg_load)
    |=> (cfg_r.count == $past(cfg_r.count) - xfer_pkg::CNT_ONE))
    else $error("count did not drop after a write");

endmodule
`default_nettype wire

/* rtl/transfer_controller.sv */
// Four channel transfer controller with fixed peripheral request routing.
// Assumes peripheral requests come from logic on ref_clk and a single-cycle core bus port.
`timescale 1ns/1ps
`default_nettype none
module transfer_controller (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire xfer_pkg::per_req_s per_req,
  output xfer_pkg::per_req_s per_ack,
  input wire logic [xfer_pkg::NUM_CH-1:0] sw_req,
  input wire xfer_pkg::ch_cfg_s [xfer_pkg::NUM_CH-1:0] ch_cfg,
  input wire logic [xfer_pkg::NUM_CH-1:0] cfg_load,
  input wire logic [xfer_pkg::NUM_CH-1:0] ch_dir_write,
  input wire logic cpu_bus_req,
  output logic cpu_bus_gnt,
  output xfer_pkg::bus_req_s bus_out,
  input wire logic [xfer_pkg::DATA_W-1:0] bus_rdata,
  output logic [xfer_pkg::NUM_CH-1:0] ch_busy,
  output logic [xfer_pkg::NUM_CH-1:0] ch_done
);

  localparam int N = xfer_pkg::NUM_CH;

  logic [N-1:0] prim_req, sec_req, prim_ack, sec_ack, ch_req, grant;
  xfer_pkg::bus_req_s [N-1:0] ch_bus;
  logic steal_r;
  logic [1:0] rr_r;

  // ==========================================================================
  // Request routing
  // ==========================================================================
  // Channel 0 is fed by the USB node, then by UART receive.
  assign prim_req[0] = per_req.usb;
  assign sec_req[0] = per_req.uart_rx;
  // Channel 1 is fed by UART transmit, its secondary input is tied off.
  assign prim_req[1] = per_req.uart_tx;
  assign sec_req[1] = 1'b0;
  // Audio port and converter reads on channel 2, audio port writes on channel 3.
  assign prim_req[2] = per_req.audio_rx;
  assign sec_req[2] = per_req.conv_rx;
  assign prim_req[3] = per_req.audio_tx;
  // Converter writes on channel 3 secondary.
  assign sec_req[3] = per_req.conv_tx;

  // Acknowledges return to the same fixed source.
  assign per_ack.usb = prim_ack[0];
  assign per_ack.uart_rx = sec_ack[0];
  assign per_ack.uart_tx = prim_ack[1];
  assign per_ack.audio_rx = prim_ack[2];
  assign per_ack.conv_rx = sec_ack[2];
  assign per_ack.audio_tx = prim_ack[3];
  assign per_ack.conv_tx = sec_ack[3];

  // ==========================================================================
  // Cycle stealing arbitration
  // ==========================================================================
  // Rotating pick among channels, so no channel starves another.
  function automatic logic [N-1:0] rr_pick(input logic [N-1:0] r, input logic [1:0] base);
    logic [N-1:0] g;
    logic [1:0] k;
    g = '0;
    for (int i = N - 1; i >= 0; i--) begin
      k = base + 2'(i);
      if (r[k]) begin
        g = '0;
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction

  // A stolen cycle is followed by a free one whenever the processor wants it.
  wire logic dma_turn = |ch_req && !(cpu_bus_req && steal_r);
  assign grant = dma_turn ? rr_pick(ch_req, rr_r) : '0;
  assign cpu_bus_gnt = cpu_bus_req && !dma_turn;

  always_comb begin
    bus_out = '0;
    for (int i = 0; i < N; i++) begin
      if (grant[i]) begin
        bus_out = ch_bus[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      steal_r <= 1'b0;
      rr_r <= 2'h0;
    end else if (clk_en) begin
      steal_r <= dma_turn;
      if (dma_turn) begin
        rr_r <= rr_r + 2'h1;
      end
    end
  end

  // ==========================================================================
  // Channels
  // ==========================================================================
  // Four copies, each run on its own.
  genvar c;
  generate
    for (c = 0; c < N; c++) begin : g_ch
      xfer_pkg::ch_cfg_s cfg_c;
      xfer_pkg::req_src_e src_c;
      always_comb begin
        cfg_c = ch_cfg[c];
        if (ch_dir_write[c] && cfg_c.dir == xfer_pkg::DIR_MEM_TO_MEM) begin
          cfg_c.dir = xfer_pkg::DIR_MEM_TO_PER;
        end
      end
      xfer_channel u_ch (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cfg(cfg_c),
        .cfg_load(cfg_load[c]),
        .prim_req(prim_req[c]),
        .sec_req(sec_req[c]),
        .sw_req(sw_req[c]),
        .grant(grant[c]),
        .bus_done(clk_en),
        .bus_rdata(bus_rdata),
        .bus_out(ch_bus[c]),
        .src(src_c),
        .prim_ack(prim_ack[c]),
        .sec_ack(sec_ack[c]),
        .busy(ch_busy[c]),
        .finished(ch_done[c])
      );
      assign ch_req[c] = ch_bus[c].req;
    end
  endgenerate

  a_cpu_gets_turn: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && dma_turn && cpu_bus_req) |=> (!cpu_bus_req || cpu_bus_gnt))
    else $error("processor denied two cycles in a row");

  a_one_grant: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot0({grant, cpu_bus_gnt}))
    else $error("more than one bus master granted");

  a_ch1_sec_dead: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sec_ack[1])
    else $error("unused secondary on channel 1 acknowledged");

  a_usb_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_ack.usb |-> prim_ack[0])
    else $error("USB acknowledge not from channel 0 primary");

  // ==========================================================================
  // Bus sharing and routing checks
  // ==========================================================================
  // The acknowledges are combinational, so a wrong route shows in the same cycle.
  a_freeze_arb: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> ($stable(rr_r) && $stable(steal_r)))
    else $error("arbiter state moved while the clock enable was low");

  a_cpu_alone: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cpu_bus_req && !(|ch_req)) |-> cpu_bus_gnt)
    else $error("processor kept off an idle bus");

  a_gnt_wanted: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_bus_gnt |-> cpu_bus_req)
    else $error("processor granted without asking");

  a_dma_moves: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((|ch_req) && !cpu_bus_req) |-> (|grant))
    else $error("waiting channel not served on a free bus");

  a_grant_wanted: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(|(grant & ~ch_req)))
    else $error("channel granted without a request");

  a_bus_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(|grant) |-> (bus_out == '0))
    else $error("bus driven with no channel granted");

  a_rr_rotates: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && (|grant)) |=> (rr_r != $past(rr_r)))
    else $error("round robin pointer stuck after a stolen cycle");

  a_one_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot0(per_ack))
    else $error("more than one peripheral acknowledged");

  a_ack_on_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|per_ack) |-> (bus_out.req && bus_out.wr))
    else $error("acknowledge outside a granted write");

  a_ack_wanted: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(|(per_ack & ~per_req)))
    else $error("acknowledge for a request that is not standing");

  a_uart_rx_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_ack.uart_rx |-> grant[0])
    else $error("UART receive acknowledge not from channel 0");

  a_uart_tx_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_ack.uart_tx |-> grant[1])
    else $error("UART transmit acknowledge not from channel 1");

  a_ch2_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (per_ack.audio_rx || per_ack.conv_rx) |-> grant[2])
    else $error("read acknowledge not from channel 2");

  a_audio_tx_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_ack.audio_tx |-> grant[3])
    else $error("audio write acknowledge not from channel 3");

  a_conv_tx_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_ack.conv_tx |-> grant[3])
    else $error("converter write acknowledge not from channel 3");

  a_ch1_src: assert property (@(posedge ref_clk) disable iff (!rst_n)
    g_ch[1].src_c != xfer_pkg::SRC_SECONDARY)
    else $error("channel 1 served its unused secondary");

endmodule
`default_nettype wire

/* testbench/periph_model.sv */
// Peripheral request lines and core bus memory as seen by the transfer controller.
// Assumes the bench pulses raise for one cycle and every party runs on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire xfer_pkg::per_req_s raise,
  input wire xfer_pkg::per_req_s per_ack,
  input wire xfer_pkg::bus_req_s bus_out,
  output xfer_pkg::per_req_s per_req,
  output logic [xfer_pkg::DATA_W-1:0] bus_rdata
);
  logic [xfer_pkg::DATA_W-1:0] idle_r;
  logic rd_cycle;

  // ==========================================================================
  // Requests
  // ==========================================================================
  // Seven sources, held until acknowledged.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_req <= '0;
      idle_r <= 16'h0000;
    end else begin
      per_req <= (per_req & ~per_ack) | raise;
      idle_r <= idle_r ^ 16'hffff ^ 16'h0001;
    end
  end

  // Outside a granted read all data lines but bit 0 move every cycle, so stale data never matches.
  assign rd_cycle = bus_out.req && !bus_out.wr;
  assign bus_rdata = rd_cycle ? ({bus_out.addr[7:0], bus_out.addr[15:8]} ^ 16'ha5c3) : idle_r;
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the four channel transfer controller.
// Assumes the peripheral model answers reads and holds requests until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cpu_bus_req = 1'b0;
  logic cpu_bus_gnt;
  logic [3:0] sw_req = 4'h0;
  logic [3:0] cfg_load = 4'h0;
  logic [3:0] ch_dir_write = 4'h0;
  logic [3:0] ch_busy;
  logic [3:0] ch_done;
  logic [15:0] bus_rdata;
  xfer_pkg::per_req_s per_req;
  xfer_pkg::per_req_s per_ack;
  xfer_pkg::per_req_s raise = '0;
  xfer_pkg::ch_cfg_s [3:0] ch_cfg = '0;
  xfer_pkg::bus_req_s bus_out;
  int mismatches = 0;
  int n_checks = 0;
  int ch_of [7] = '{3, 2, 3, 2, 1, 0, 0};

  always #2.5 ref_clk = ~ref_clk;

  transfer_controller i_transfer_controller (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .per_req(per_req), .per_ack(per_ack), .sw_req(sw_req), .ch_cfg(ch_cfg), .cfg_load(cfg_load),
    .ch_dir_write(ch_dir_write), .cpu_bus_req(cpu_bus_req), .cpu_bus_gnt(cpu_bus_gnt),
    .bus_out(bus_out), .bus_rdata(bus_rdata), .ch_busy(ch_busy), .ch_done(ch_done));
  periph_model i_periph_model (.ref_clk(ref_clk), .rst_n(rst_n), .raise(raise),
    .per_ack(per_ack), .bus_out(bus_out), .per_req(per_req), .bus_rdata(bus_rdata));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] mem_word(input logic [23:0] a);
    return {a[7:0], a[15:8]} ^ 16'ha5c3;
  endfunction

  task automatic check(input string n, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic load(input int ch, input xfer_pkg::xfer_dir_e dr, input logic en,
                      input logic [15:0] cnt, input logic [23:0] s, input logic [23:0] d);
    @(posedge ref_clk);
    ch_cfg[ch] <= '{enable: en, dir: dr, src_addr: s, dst_addr: d, count: cnt};
    cfg_load[ch] <= 1'b1;
    @(posedge ref_clk);
    cfg_load[ch] <= 1'b0;
  endtask

  task automatic expect_xfer(input int ch, input logic [23:0] s, input logic [23:0] d,
                             input logic [6:0] ack, input logic last);
    int k;
    k = 0;
    do begin @(negedge ref_clk); k++; end while (!(bus_out.req && !bus_out.wr) && k < 30);
    check("read addr", bus_out.addr, s);
    check("cpu held off", cpu_bus_gnt, 1'b0);
    check("busy", ch_busy[ch], 1'b1);
    @(negedge ref_clk);
    check("cpu slot", cpu_bus_gnt, cpu_bus_req);
    k = 0;
    while (!(bus_out.req && bus_out.wr) && k < 30) begin @(negedge ref_clk); k++; end
    check("write addr", bus_out.addr, d);
    check("write data", bus_out.wdata, mem_word(s));
    check("ack", per_ack, ack);
    // The done pulse stands only in the cycle after the write, and only for the last word.
    @(negedge ref_clk);
    check("done", ch_done[ch], last);
    check("idle", ch_busy[ch], 1'b0);
  endtask

  task automatic pulse_sw(input logic [3:0] m);
    @(posedge ref_clk);
    sw_req <= m;
    @(posedge ref_clk);
    sw_req <= 4'h0;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    logic [23:0] s;
    logic [23:0] d;
    logic [3:0] acc;
    int nw;
    s = $urandom(32'hddfd32c8);
    @(negedge ref_clk);
    check("reset outputs", {ch_busy, ch_done, per_ack, bus_out.req}, 24'h0);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    $display("test reset done");
    for (int k = 0; k < 7; k++) begin
      s = $urandom & 24'hfffffe;
      d = $urandom & 24'hfffffe;
      load(ch_of[k], k[0] ? xfer_pkg::DIR_PER_TO_MEM : xfer_pkg::DIR_MEM_TO_PER, 1'b1,
           16'h0001, s, d);
      raise <= 7'h01 << k;
      cpu_bus_req <= 1'($urandom);
      @(posedge ref_clk);
      raise <= '0;
      expect_xfer(ch_of[k], s, d, 7'h01 << k, 1'b1);
    end
    cpu_bus_req <= 1'b0;
    $display("test routing done");
    load(0, xfer_pkg::DIR_PER_TO_MEM, 1'b1, 16'h0001, 24'h000100, 24'h000200);
    raise <= 7'h60;
    @(posedge ref_clk);
    raise <= '0;
    expect_xfer(0, 24'h000100, 24'h000200, 7'h40, 1'b1);
    load(0, xfer_pkg::DIR_PER_TO_MEM, 1'b1, 16'h0001, 24'h000300, 24'h000400);
    expect_xfer(0, 24'h000300, 24'h000400, 7'h20, 1'b1);
    $display("test priority done");
    // Software request, memory to memory; channel 1 turned into memory to peripheral.
    @(posedge ref_clk);
    ch_dir_write <= 4'h2;
    for (int c = 0; c < 4; c++) begin
      s = $urandom & 24'h00fffe;
      d = $urandom & 24'h00fffe;
      load(c, xfer_pkg::DIR_MEM_TO_MEM, 1'b1, 16'h0002, s, d);
      pulse_sw(4'h1 << c);
      expect_xfer(c, s, d, 7'h00, 1'b0);
      pulse_sw(4'h1 << c);
      expect_xfer(c, s + 24'h2, (c == 1) ? d : d + 24'h2, 7'h00, 1'b1);
    end
    $display("test software done");
    // Clock enable low freezes a started transfer.
    load(0, xfer_pkg::DIR_MEM_TO_MEM, 1'b1, 16'h0001, 24'h000020, 24'h000030);
    pulse_sw(4'h1);
    clk_en <= 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      check("frozen", {ch_busy, ch_done, bus_out.req}, 24'h000021);
    end
    @(posedge ref_clk);
    clk_en <= 1'b1;
    expect_xfer(0, 24'h000020, 24'h000030, 7'h00, 1'b1);
    $display("test freeze done");
    load(2, xfer_pkg::DIR_MEM_TO_MEM, 1'b0, 16'h0001, 24'h0, 24'h10);
    load(3, xfer_pkg::DIR_MEM_TO_MEM, 1'b1, 16'h0000, 24'h0, 24'h10);
    pulse_sw(4'hc);
    acc = 4'h0;
    repeat (10) @(negedge ref_clk) acc = acc | ch_busy | {3'h0, bus_out.req};
    check("refused start", acc, 4'h0);
    $display("test refusal done");
    for (int c = 0; c < 4; c++) begin
      load(c, xfer_pkg::DIR_MEM_TO_MEM, 1'b1, 16'h0001, 24'h000040 * c, 24'h000800);
    end
    pulse_sw(4'hf);
    acc = 4'h0;
    nw = 0;
    repeat (40) begin
      @(negedge ref_clk);
      acc = acc | ch_done;
      nw += (bus_out.req && bus_out.wr) ? 1 : 0;
    end
    check("all done", acc, 4'hf);
    check("write count", nw, 4);
    $display("test independence done");
    finish_test();
  end

  initial begin
    #50us;
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
